/* File: core/qrce_engine.sv */
`timescale 1ns/1ps
module qrce_engine
    import qrce_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk_pin,
    input wire logic cs_pin_n,
    input wire logic [3:0] io_pin_in,
    output logic [3:0] io_pin_out,
    output logic [3:0] io_pin_oe
);
    // Memory must hold a whole 64-byte wrap section
    if (MEM_AW < 6 || MEM_AW > 16) begin : g_bad_aw
        $error("MEM_AW out of range");
    end

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [5:0] sync1_r, sync2_r;
    logic sclk_d_r, cs_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else if (clk_en) begin
            sync1_r <= {sclk_pin, cs_pin_n, io_pin_in};
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[5];
            cs_d_r <= sync2_r[4];
        end
    end

    logic cs_n_s, rise, fall, cs_fall;
    logic [3:0] io_s;
    assign cs_n_s = sync2_r[4];
    assign io_s = sync2_r[3:0];
    assign rise = clk_en && sync2_r[5] && !sclk_d_r;
    assign fall = clk_en && !sync2_r[5] && sclk_d_r;
    assign cs_fall = clk_en && !cs_n_s && cs_d_r;

    // ****************************************
    // Control register
    // ****************************************
    logic quad_lines_enable_bit, addr4_mode, quad_command_mode;
    logic soft_rst;
    logic apb_wr, apb_rd_setup;
    assign apb_wr = clk_en && psel && penable && pwrite;
    assign apb_rd_setup = clk_en && psel && !penable && !pwrite;
    assign soft_rst = apb_wr && paddr == REG_CTRL && pwdata[CTRL_SRST_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {quad_command_mode, addr4_mode, quad_lines_enable_bit} <= CTRL_RESET;
        end else if (apb_wr && paddr == REG_CTRL) begin
            quad_lines_enable_bit <= pwdata[CTRL_QLE_BIT];
            addr4_mode <= pwdata[CTRL_ADDR4_BIT];
            quad_command_mode <= pwdata[CTRL_QCM_BIT];
        end
    end

    // ****************************************
    // Serial command sequencer
    // ****************************************
    qrce_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] op_r, op_w, mode_r, cfg_r;
    logic [7:0] mode_w, cfg_w;
    logic cont_r;
    logic [2:0] wrap_config_bits;
    logic [1:0] param_r;
    logic last;

    assign last = cnt_r == 4'h1;
    assign op_w = quad_command_mode ? {op_r[3:0], io_s} : {op_r[6:0], io_s[0]};
    assign mode_w = {mode_r[3:0], io_s};
    assign cfg_w = {cfg_r[3:0], io_s};

    function automatic logic [3:0] addr_clks(input logic [7:0] op, input logic a4);
        addr_clks = (op == OP_QREAD4 || a4) ? ADDR4_CLKS : ADDR3_CLKS;
    endfunction

    qrce_state_t dec_state;
    logic [3:0] dec_cnt;
    always_comb begin
        dec_state = ST_IGNORE;
        dec_cnt = 4'h0;
        case (op_w)
            OP_QREAD: begin
                if (quad_lines_enable_bit) begin
                    dec_state = ST_ADDR;
                    dec_cnt = addr_clks(op_w, addr4_mode);
                end
            end
            OP_QREAD4, OP_WREAD: begin
                if (quad_lines_enable_bit && !quad_command_mode) begin
                    dec_state = ST_ADDR;
                    dec_cnt = addr_clks(op_w, addr4_mode);
                end
            end
            OP_SETWRAP: begin
                if (!quad_command_mode) begin
                    dec_state = ST_WRAPCFG;
                    dec_cnt = addr_clks(8'h00, addr4_mode) + WRAP_BYTE_CLKS;
                end
            end
            OP_SETPARAM: begin
                if (quad_command_mode) begin
                    dec_state = ST_PARAM;
                    dec_cnt = PARAM_CLKS;
                end
            end
            default: begin
                dec_state = ST_IGNORE;
            end
        endcase
    end

    logic [3:0] dummy_clks;
    always_comb begin
        if (quad_command_mode) begin
            dummy_clks = {1'b0, param_r, 1'b0};
        end else if (op_r == OP_WREAD) begin
            dummy_clks = DUMMY_WREAD;
        end else begin
            dummy_clks = DUMMY_QREAD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
        end else if (clk_en) begin
            if (cs_n_s) begin
                state_r <= ST_IDLE;
            end else if (cs_fall) begin
                state_r <= cont_r ? ST_ADDR : ST_CMD;
                if (cont_r) begin
                    cnt_r <= addr_clks(op_r, addr4_mode);
                end else begin
                    cnt_r <= quad_command_mode ? CMD_CLKS_QCM : CMD_CLKS_SPI;
                end
            end else if (rise) begin
                cnt_r <= cnt_r - 4'h1;
                case (state_r)
                    ST_CMD: begin
                        if (last) begin
                            state_r <= dec_state;
                            cnt_r <= dec_cnt;
                        end
                    end
                    ST_ADDR: begin
                        if (last) begin
                            state_r <= ST_MODE;
                            cnt_r <= MODE_CLKS;
                        end
                    end
                    ST_MODE: begin
                        if (last) begin
                            state_r <= (dummy_clks == 4'h0) ? ST_DATA : ST_DUMMY;
                            cnt_r <= dummy_clks;
                        end
                    end
                    ST_DUMMY: begin
                        if (last) begin
                            state_r <= ST_DATA;
                        end
                    end
                    ST_WRAPCFG, ST_PARAM: begin
                        if (last) begin
                            state_r <= ST_IGNORE;
                        end
                    end
                    default: begin
                        cnt_r <= cnt_r;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Shift registers for opcode, mode and setup bytes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r <= 8'h00;
            mode_r <= 8'h00;
            cfg_r <= 8'h00;
        end else if (rise && !cs_n_s && !cs_fall) begin
            if (state_r == ST_CMD) begin
                op_r <= op_w;
            end
            if (state_r == ST_MODE) begin
                mode_r <= mode_w;
            end
            if (state_r == ST_WRAPCFG || state_r == ST_PARAM) begin
                cfg_r <= cfg_w;
            end
        end
    end

    // Opcode skip flag survives select going high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cont_r <= 1'b0;
        end else if (soft_rst) begin
            cont_r <= 1'b0;
        end else if (rise && !cs_n_s && !cs_fall && state_r == ST_MODE && last) begin
            cont_r <= mode_w[5:4] == SKIP_CODE;
        end
    end

    // Wrap and dummy settings from the serial setup commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_config_bits <= WRAP_RESET;
            param_r <= PARAM_RESET;
        end else if (soft_rst) begin
            wrap_config_bits <= WRAP_RESET;
            param_r <= PARAM_RESET;
        end else if (rise && !cs_n_s && !cs_fall && last) begin
            if (state_r == ST_WRAPCFG) begin
                wrap_config_bits <= cfg_w[6:4];
            end
            if (state_r == ST_PARAM) begin
                param_r <= cfg_w[5:4];
            end
        end
    end

    // ****************************************
    // Address counter with wrap
    // ****************************************
    logic [31:0] addr_r, addr_inc, wmask;
    logic wrap_on, half_r, advance;
    assign wrap_on = !wrap_config_bits[0] && !quad_command_mode;
    assign wmask = (32'h8 << wrap_config_bits[2:1]) - 32'h1;
    assign advance = fall && !cs_n_s && state_r == ST_DATA && half_r;
    always_comb begin
        if (wrap_on) begin
            addr_inc = (addr_r & ~wmask) | ((addr_r + 32'h1) & wmask);
        end else begin
            addr_inc = addr_r + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= 32'h0;
        end else if (cs_fall) begin
            addr_r <= 32'h0;
        end else if (rise && !cs_n_s && state_r == ST_ADDR) begin
            addr_r <= {addr_r[27:0], io_s};
        end else if (advance) begin
            addr_r <= addr_inc;
        end
    end

    // ****************************************
    // Data output on falling serial edges
    // ****************************************
    logic [7:0] rd_byte;
    logic drive_r;
    logic [MEM_AW-1:0] maddr_r;
    logic mem_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= 1'b0;
            half_r <= 1'b0;
            io_pin_out <= 4'h0;
        end else if (clk_en) begin
            if (cs_n_s || state_r != ST_DATA) begin
                drive_r <= 1'b0;
                half_r <= 1'b0;
            end else if (fall) begin
                drive_r <= 1'b1;
                half_r <= !half_r;
                io_pin_out <= half_r ? rd_byte[3:0] : rd_byte[7:4];
            end
        end
    end
    assign io_pin_oe = {4{drive_r}};

    assign mem_wr = apb_wr && paddr == REG_MDATA;
    qrce_mem #(.AW(MEM_AW)) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(mem_wr),
        .wr_addr(maddr_r),
        .wr_data(pwdata[7:0]),
        .rd_addr(addr_r[MEM_AW-1:0]),
        .rd_data(rd_byte)
    );

    // ****************************************
    // APB slave
    // ****************************************
    logic mapped;
    assign mapped = paddr inside {REG_CTRL, REG_WRAP, REG_PARAM, REG_STATUS,
                                  REG_MADDR, REG_MDATA};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maddr_r <= '0;
        end else if (apb_wr && paddr == REG_MADDR) begin
            maddr_r <= pwdata[MEM_AW-1:0];
        end else if (mem_wr) begin
            maddr_r <= maddr_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_rd_setup) begin
            case (paddr)
                REG_CTRL: prdata <= {29'h0, quad_command_mode, addr4_mode,
                                     quad_lines_enable_bit};
                REG_WRAP: prdata <= {25'h0, wrap_config_bits, 4'h0};
                REG_PARAM: prdata <= {26'h0, param_r, 4'h0};
                REG_STATUS: prdata <= {24'h0, 4'(state_r), 2'h0, !cs_n_s, cont_r};
                REG_MADDR: prdata <= 32'(maddr_r);
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cmd_end, mode_end;
    assign cmd_end = rise && !cs_n_s && !cs_fall && state_r == ST_CMD && last;
    assign mode_end = rise && !cs_n_s && !cs_fall && state_r == ST_MODE && last;

    qle_gate_a: assert property (cmd_end && op_w == OP_QREAD && !quad_lines_enable_bit
        |=> state_r == ST_IGNORE) else $error("quad read taken without enable");
    word_gate_a: assert property (cmd_end && op_w == OP_WREAD && !quad_lines_enable_bit
        |=> state_r == ST_IGNORE) else $error("word read taken without enable");
    qcm_four_a: assert property (cmd_end && op_w == OP_QREAD4 && quad_command_mode
        |=> state_r == ST_IGNORE) else $error("four byte read taken in quad mode");
    skip_set_a: assert property (mode_end && mode_w[5:4] == SKIP_CODE
        |=> cont_r) else $error("skip flag not set");
    skip_clear_a: assert property (mode_end && mode_w[5:4] != SKIP_CODE
        |=> !cont_r) else $error("skip flag not cleared");
    skip_resume_a: assert property (cs_fall && cont_r
        |=> state_r == ST_ADDR) else $error("skipped opcode not resumed");
    spi_dummy_a: assert property (mode_end && !quad_command_mode && op_r == OP_QREAD
        |=> state_r == ST_DUMMY && cnt_r == 4'h4) else $error("quad read dummy count");
    word_dummy_a: assert property (mode_end && !quad_command_mode && op_r == OP_WREAD
        |=> state_r == ST_DUMMY && cnt_r == 4'h2) else $error("word read dummy count");
    qcm_nodummy_a: assert property (mode_end && quad_command_mode && param_r == 2'h0
        |=> state_r == ST_DATA) else $error("default quad mode data late");
    no_drive_a: assert property (state_r == ST_IGNORE |-> ##1 io_pin_oe == 4'h0)
        else $error("lines driven after ignored opcode");
    wrap_stay_a: assert property (advance && wrap_on
        |=> (addr_r >> (4'h3 + $past(wrap_config_bits[2:1])))
            == ($past(addr_r) >> (4'h3 + $past(wrap_config_bits[2:1])))
            && addr_r[2:0] == 3'($past(addr_r[2:0]) + 3'h1))
        else $error("wrap left its section");
    qcm_nowrap_a: assert property (advance && quad_command_mode
        |=> addr_r == $past(addr_r) + 32'h1) else $error("wrapped in quad mode");
    reset_dflt_a: assert property (soft_rst
        |=> param_r == 2'h0 && wrap_config_bits[0]) else $error("reset defaults lost");

    skip_cov: cover property (cs_fall && cont_r);
    wrap_cov: cover property (advance && wrap_on && addr_inc[2:0] == 3'h0);
    qcm_cov: cover property (mode_end && quad_command_mode);
endmodule // qrce_engine

/* File: core/qrce_pkg.sv */
// How it works
// - Quad read opcode sends address and data four bits per clock, four dummies outside quad command mode.
// - Quad read opcode accepted only with the quad lines enable bit set.
// - Eight mode bits follow the address; only the upper nibble matters.
// - Mode bits 5:4 at 10 make the next select period skip its opcode.
// - Any other mode bits 5:4 value makes the next period expect an opcode.
// - Wrapped data runs to the aligned section end, then restarts at its start.
// - Wrap configuration is three bits: disable bit and two length bits.
// - A set wrap command steers all later quad reads outside quad command mode until changed.
// - Quad command mode dummies follow parameter bits 5:4: 0, 2, 4 or 6.
// - Quad command mode dummy setting defaults to zero after any reset.
// - In quad command mode the mode byte is still decoded; its two clocks come before the dummy clocks.
// - Opcode skipping also works for quad read in quad command mode.
// - Quad read in quad command mode never wraps.
// - Four byte quad read opcode always takes a 32 bit address.
// - Four byte quad read opcode is recognised only in single line mode.
// - Four byte quad read honours the wrap configuration too.
// - Word read takes an even address and only two dummy clocks.
// - Word read accepted only with the quad lines enable bit set.
// - Word read supports opcode skipping through mode bits 5:4.
// - Reads use 32 bit addresses in four byte mode or with the four byte opcode, else 24 bit.
// - Wrap disable bit resets to one after every kind of reset.
package qrce_pkg;
    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_QREAD = 8'hEB;
    localparam logic [7:0] OP_QREAD4 = 8'hEC;
    localparam logic [7:0] OP_WREAD = 8'hE7;
    localparam logic [7:0] OP_SETWRAP = 8'h77;
    localparam logic [7:0] OP_SETPARAM = 8'hC0;
    // ****************************************
    // Register offsets and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WRAP = 8'h04;
    localparam logic [7:0] REG_PARAM = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MADDR = 8'h10;
    localparam logic [7:0] REG_MDATA = 8'h14;
    localparam int CTRL_QLE_BIT = 0;
    localparam int CTRL_ADDR4_BIT = 1;
    localparam int CTRL_QCM_BIT = 2;
    localparam int CTRL_SRST_BIT = 3;
    localparam int WRAP_LSB = 4;
    localparam int PARAM_LSB = 4;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [2:0] WRAP_RESET = 3'h1;
    localparam logic [1:0] PARAM_RESET = 2'h0;
    localparam logic [1:0] SKIP_CODE = 2'h2;
    localparam logic [5:0] SYNC_RESET = 6'h10;
    // ****************************************
    // Clock counts on the serial link
    // ****************************************
    localparam logic [3:0] CMD_CLKS_SPI = 4'h8;
    localparam logic [3:0] CMD_CLKS_QCM = 4'h2;
    localparam logic [3:0] ADDR3_CLKS = 4'h6;
    localparam logic [3:0] ADDR4_CLKS = 4'h8;
    localparam logic [3:0] MODE_CLKS = 4'h2;
    localparam logic [3:0] WRAP_BYTE_CLKS = 4'h2;
    localparam logic [3:0] PARAM_CLKS = 4'h2;
    localparam logic [3:0] DUMMY_QREAD = 4'h4;
    localparam logic [3:0] DUMMY_WREAD = 4'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY,
        ST_DATA, ST_WRAPCFG, ST_PARAM, ST_IGNORE
    } qrce_state_t;
endpackage

/* File: core/qrce_mem.sv */
`timescale 1ns/1ps
module qrce_mem #(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge pclk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // qrce_mem

/* File: verification/qrce_host_model.sv */
`timescale 1ns/1ps
module qrce_host_model (
    output logic sclk_pin,
    output logic cs_pin_n,
    output logic [3:0] io_pin_in,
    input wire logic [3:0] io_pin_out,
    input wire logic [3:0] io_pin_oe,
    output logic [8:0] rx_data,
    output logic rx_stb
);
    logic [3:0] hv = 4'h0;
    initial begin
        sclk_pin = 1'b0;
        cs_pin_n = 1'b1;
        rx_data = 9'h000;
        rx_stb = 1'b0;
    end
    // ********
    // Wire level; a released line toggles each clock so no stale value survives
    // ********
    always_comb begin
        for (int i = 0; i < 4; i++) io_pin_in[i] = io_pin_oe[i] ? io_pin_out[i] : hv[i];
    end
    task automatic clk(input logic [3:0] v, input logic drv, output logic [3:0] s);
        hv = drv ? v : ~hv;
        #100 s = io_pin_in;
        sclk_pin = 1'b1;
        #100 sclk_pin = 1'b0;
    endtask
    task automatic frame(input logic [31:0] op, input int opc, input logic [31:0] a,
                         input int ac, input logic [7:0] md, input int dc, input int nb);
        logic [3:0] s, hi;
        logic ok;
        #37 cs_pin_n = 1'b0;
        #150;
        for (int i = opc - 1; i >= 0; i--)
            clk((opc == 8) ? {3'b000, op[i]} : op[4*i+:4], 1'b1, s);
        for (int i = ac - 1; i >= 0; i--) clk(a[4*i+:4], 1'b1, s);
        clk(md[7:4], 1'b1, s);
        clk(md[3:0], 1'b1, s);
        for (int i = 0; i < dc; i++) clk(4'h0, 1'b0, s);
        for (int n = 0; n < nb; n++) begin
            clk(4'h0, 1'b0, hi);
            ok = (io_pin_oe === 4'hF);
            clk(4'h0, 1'b0, s);
            ok = ok && (io_pin_oe === 4'hF);
            rx_data = ok ? {1'b1, hi, s} : 9'h000;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
        #50 cs_pin_n = 1'b1;
        #1000;
    endtask
endmodule // qrce_host_model

/* File: verification/tb_quad_io_read_command_engine.sv */
`timescale 1ns/1ps
module tb_quad_io_read_command_engine;
    import qrce_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk_pin, cs_pin_n, rx_stb;
    logic [3:0] io_pin_in, io_pin_out, io_pin_oe;
    logic [8:0] rx_data;
    logic [7:0] mem [80];
    logic [7:0] a;
    logic [32:0] exp_q [$];
    logic [32:0] got, e;
    event got_e;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    qrce_engine #(.MEM_AW(8)) qrce_engine_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk_pin(sclk_pin), .cs_pin_n(cs_pin_n), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe)
    );
    qrce_host_model qrce_host_model_inst (
        .sclk_pin(sclk_pin), .cs_pin_n(cs_pin_n), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .rx_data(rx_data), .rx_stb(rx_stb)
    );
    task automatic report_and_stop();
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("[FAIL] %0t results missing", $time);
        end
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        got = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (!w) ->got_e;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, ad, 32'h0);
    endtask
    function automatic logic [7:0] at(input logic [7:0] b, input int i, input int wl);
        return (wl == 0) ? 8'(b + i) : 8'((b & ~(wl - 1)) | ((b + i) & (wl - 1)));
    endfunction
    task automatic rd(input logic [31:0] op, input int opc, input int ac, input logic [7:0] md,
                      input int dc, input int wl, input logic ok);
        for (int i = 0; i < 10; i++)
            exp_q.push_back(ok ? {24'h0, 1'b1, mem[at(a, i, wl)]} : 33'h0);
        qrce_host_model_inst.frame(op, opc, {24'h0, a}, ac, md, dc, 10);
    endtask
    // ********
    // Result checking and run limit
    // ********
    always @(posedge rx_stb) begin
        got = {24'h0, rx_data};
        ->got_e;
    end
    always @(got_e) begin
        checks++;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
        if (got !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, e);
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ********
    // Scenarios
    // ********
    initial begin
        void'($urandom(90445));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(REG_CTRL, 33'h0);
        rdchk(REG_WRAP, 33'h10);
        rdchk(REG_PARAM, 33'h0);
        rdchk(8'h40, {1'b1, 32'h0});
        for (int i = 0; i < 80; i++) begin
            mem[i] = 8'($urandom);
            apb(1'b1, REG_MADDR, i);
            apb(1'b1, REG_MDATA, {24'h0, mem[i]});
        end
        rdchk(REG_MADDR, 33'h50);
        a = 8'($urandom_range(60));
        rd(OP_QREAD, 8, 6, 8'h00, 4, 0, 1'b0);
        rd(OP_WREAD, 8, 6, 8'h00, 2, 0, 1'b0);
        apb(1'b1, REG_CTRL, 32'h1);
        clk_en <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h0);
        clk_en <= 1'b1;
        rdchk(REG_CTRL, 33'h1);
        a = 8'h05;
        rd(OP_QREAD, 8, 6, 8'h00, 4, 0, 1'b1);
        a = 8'h0A;
        rd(OP_WREAD, 8, 6, 8'h20, 2, 0, 1'b1);
        rdchk(REG_STATUS, 33'h1);
        a = 8'h12;
        rd(OP_WREAD, 0, 6, 8'hFF, 2, 0, 1'b1);
        a = 8'($urandom_range(60));
        rd(OP_QREAD, 8, 6, 8'h2F, 4, 0, 1'b1);
        rd(OP_QREAD, 0, 6, 8'hD0, 4, 0, 1'b1);
        rd(OP_QREAD, 8, 6, 8'h00, 4, 0, 1'b1);
        for (int l = 0; l < 4; l++) begin
            qrce_host_model_inst.frame(OP_SETWRAP, 8, 0, 6, 8'(l << 5), 0, 0);
            rdchk(REG_WRAP, 33'(l << 5));
            a = 8'((8 << l) - 3);
            rd(OP_QREAD, 8, 6, 8'h00, 4, 8 << l, 1'b1);
        end
        a = 8'h3C;
        rd(OP_QREAD4, 8, 8, 8'h00, 4, 64, 1'b1);
        apb(1'b1, REG_CTRL, 32'h3);
        a = 8'h1F;
        rd(OP_QREAD, 8, 8, 8'h00, 4, 64, 1'b1);
        apb(1'b1, REG_CTRL, 32'h5);
        a = 8'h3A;
        rd(OP_QREAD, 2, 6, 8'h00, 0, 0, 1'b1);
        qrce_host_model_inst.frame(OP_SETPARAM, 2, 0, 0, 8'h30, 0, 0);
        rdchk(REG_PARAM, 33'h30);
        a = 8'($urandom_range(70));
        rd(OP_QREAD, 2, 6, 8'h20, 6, 0, 1'b1);
        rd(OP_QREAD, 0, 6, 8'hFF, 6, 0, 1'b1);
        rd(OP_QREAD4, 2, 8, 8'h00, 4, 0, 1'b0);
        apb(1'b1, REG_CTRL, 32'hD);
        rdchk(REG_WRAP, 33'h10);
        rdchk(REG_PARAM, 33'h0);
        a = 8'($urandom_range(70));
        rd(OP_QREAD, 2, 6, 8'h00, 0, 0, 1'b1);
        report_and_stop();
    end
endmodule // tb_quad_io_read_command_engine
